// File: pkg/aex_pkg.sv
// Package of constants and types for the asynchronous enclave exit unit.
package aex_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_EXIT_PTR_LO = 8'h00;
    localparam logic [7:0] ADDR_EXIT_PTR_HI = 8'h04;
    localparam logic [7:0] ADDR_TCS_PTR_LO  = 8'h08;
    localparam logic [7:0] ADDR_TCS_PTR_HI  = 8'h0C;
    localparam logic [7:0] ADDR_BASE_LO     = 8'h10;
    localparam logic [7:0] ADDR_BASE_HI     = 8'h14;
    localparam logic [7:0] ADDR_OFFSET_LO   = 8'h18;
    localparam logic [7:0] ADDR_OFFSET_HI   = 8'h1C;
    localparam logic [7:0] ADDR_FRAME_PAGES = 8'h20;
    localparam logic [7:0] ADDR_SLOT_COUNT  = 8'h24;
    localparam logic [7:0] ADDR_CUR_SLOT    = 8'h28;
    localparam logic [7:0] ADDR_USP_LO      = 8'h2C;
    localparam logic [7:0] ADDR_USP_HI      = 8'h30;
    localparam logic [7:0] ADDR_UFP_LO      = 8'h34;
    localparam logic [7:0] ADDR_UFP_HI      = 8'h38;
    localparam logic [7:0] ADDR_STATUS      = 8'h3C;

    // Configuration words live in a small array indexed by address bits.
    localparam int unsigned CFG_WORDS    = 10;
    localparam int unsigned CFG_IDX_LSB  = 2;
    localparam int unsigned CFG_IDX_MSB  = 5;

    // ------------------------------------------------------------------
    // Synthetic values
    // ------------------------------------------------------------------
    localparam logic [63:0] RESUME_LEAF_IDX = 64'h0000_0000_0000_0003;
    localparam logic [63:0] FLAGS_CLR_MASK  = 64'h0000_0000_0001_08D5;
    localparam logic [15:0] FCW_FP_ERR      = 16'h037E;
    localparam logic [15:0] FCW_OTHER       = 16'h037F;
    localparam logic [15:0] FSW_FP_ERR      = 16'h8081;
    localparam logic [15:0] FSW_OTHER       = 16'h0000;
    localparam logic [31:0] SIMD_CS_FAULT   = 32'h0000_1F01;
    localparam logic [31:0] SIMD_CS_OTHER   = 32'h0000_1FB0;
    localparam logic [63:0] CR2_LOW_CLR     = 64'hFFFF_FFFF_FFFF_F000;
    localparam logic [1:0]  INIT_FEAT_MASK  = 2'h3;
    localparam logic [1:0]  INIT_HDR_BITS   = 2'h0;
    localparam int unsigned PAGE_SHIFT      = 12;
    localparam logic [31:0] SLOT_STEP       = 32'h0000_0001;

    // Exit stack choices.
    localparam logic [1:0] STACK_APP  = 2'h0;
    localparam logic [1:0] STACK_RING = 2'h1;
    localparam logic [1:0] STACK_IST  = 2'h2;

    // Exit sequencer states.
    typedef enum logic [1:0] {
        AEX_IDLE  = 2'b00,
        AEX_SAVE  = 2'b01,
        AEX_SYNTH = 2'b10
    } aex_state_t;

endpackage : aex_pkg

// File: rtl/aex_unit.sv
// Asynchronous enclave exit unit: frame selection, save, synthetic state.
//
// Strobed register access and the register addresses are this design's own decisions.

// What this block does
// - Exit loads instruction pointer with exit pointer.
// - Restore untrusted stack and frame pointers.
// - Exit stack chosen as outside enclave.
// - Accumulator 3, base gets struct, counter pointer.
// - Clear arithmetic and resume flags only.
// - Zero data, source, destination; extended in 64-bit.
// - Low 32 bits only in 32-bit mode.
// - Other x87 and SIMD state to init.
// - Control word 037E on fp error, else 037F.
// - Status word 8081 on fp error, else 0.
// - SIMD control 1F01 on SIMD fault, else 1FB0.
// - Page fault exit clears fault-address low 12 bits.
// - Page fault to VM exit: no update.
// - Fault during delivery does not clear bits.
// - Extra segments restored from latest entry or resume.
// - Use current slot frame, save, then increment.
// - Frame at base plus offset plus slot pages.
// - Entry fails unless current slot below count.
// - Resume restores from the frame below the current slot, frees it.
// - Extended-state section uses standard save layout.
module aex_unit (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        NRST_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,
    input  wire logic        EVT_IN,
    input  wire logic        EVT_FP_ERR_IN,
    input  wire logic        EVT_SIMD_IN,
    input  wire logic        EVT_PF_IN,
    input  wire logic        EVT_PF_VMEXIT_IN,
    input  wire logic        EVT_PF_DELIVERY_IN,
    input  wire logic        MODE64_IN,
    input  wire logic        PRIV_CHANGE_IN,
    input  wire logic        IST_USE_IN,
    input  wire logic [63:0] FLAGS_IN,
    input  wire logic [63:0] CR2_IN,
    input  wire logic [63:0] SP_IN,
    input  wire logic [63:0] FP_IN,
    input  wire logic [15:0] FS_SEL_IN,
    input  wire logic [15:0] GS_SEL_IN,
    input  wire logic        ENTER_REQ_IN,
    input  wire logic        RESUME_REQ_IN,
    output logic             ENTER_OK_OUT,
    output logic             ENTER_FAIL_OUT,
    output logic             RESUME_OK_OUT,
    output logic             RESUME_FAIL_OUT,
    output logic             SAVE_STB_OUT,
    output logic             RESTORE_STB_OUT,
    output logic [63:0]      FRAME_ADDR_OUT,
    output logic             SYNTH_STB_OUT,
    output logic             SYNTH_WIDE_OUT,
    output logic             ZERO_DSI_OUT,
    output logic             EXT_ZERO_OUT,
    output logic             X87_INIT_OUT,
    output logic [1:0]       INIT_FEAT_OUT,
    output logic [1:0]       INIT_HDR_OUT,
    output logic [63:0]      ACC_OUT,
    output logic [63:0]      BASE_GPR_OUT,
    output logic [63:0]      CNT_OUT,
    output logic [63:0]      SP_OUT,
    output logic [63:0]      FP_OUT,
    output logic [63:0]      IP_OUT,
    output logic [63:0]      FLAGS_OUT,
    output logic [15:0]      FCW_OUT,
    output logic [15:0]      FSW_OUT,
    output logic [31:0]      SIMD_CS_OUT,
    output logic [63:0]      CR2_OUT,
    output logic             CR2_WE_OUT,
    output logic [15:0]      FS_SEL_OUT,
    output logic [15:0]      GS_SEL_OUT,
    output logic [1:0]       STACK_SEL_OUT
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [31:0]             cfg_q [0:aex_pkg::CFG_WORDS-1];
    logic [31:0]             cur_slot_q;
    logic [63:0]             usp_q;
    logic [63:0]             ufp_q;
    logic [15:0]             fs_q;
    logic [15:0]             gs_q;
    logic                    enter_fail_q;
    aex_pkg::aex_state_t     state_q;
    logic [63:0]             flags_q;
    logic [63:0]             cr2_q;
    logic                    fp_err_q;
    logic                    simd_q;
    logic                    pf_clear_q;
    logic                    wide_q;
    logic [1:0]              stack_q;
    logic [63:0]             frame_addr;
    logic [63:0]             exit_ptr;
    logic [63:0]             tcs_ptr;
    logic [63:0]             slot_bytes;
    logic [31:0]             frame_slot;
    logic                    idle;
    logic                    enter_go;
    logic                    resume_go;
    logic [3:0]              cfg_idx;

    assign exit_ptr = {cfg_q[1], cfg_q[0]};
    assign tcs_ptr  = {cfg_q[3], cfg_q[2]};
    assign idle     = (state_q == aex_pkg::AEX_IDLE) && !EVT_IN;
    assign enter_go  = idle && ENTER_REQ_IN;
    assign resume_go = idle && !ENTER_REQ_IN && RESUME_REQ_IN;
    assign cfg_idx   = ADDR_IN[aex_pkg::CFG_IDX_MSB:aex_pkg::CFG_IDX_LSB];

    // ------------------------------------------------------------------
    // Frame address
    // ------------------------------------------------------------------
    // Slot times pages, scaled to bytes; the product is kept at 64 bits so
    // large page counts cannot wrap before the shift.
    // A resume restores the frame that the last exit filled, one below the slot.
    assign frame_slot = resume_go ? cur_slot_q - aex_pkg::SLOT_STEP : cur_slot_q;
    assign slot_bytes = ({32'h0000_0000, frame_slot} * {32'h0000_0000, cfg_q[8]})
                        << aex_pkg::PAGE_SHIFT;
    assign frame_addr = {cfg_q[5], cfg_q[4]} + {cfg_q[7], cfg_q[6]}
                        + slot_bytes;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    // Configuration writes; index 8 and 9 hold page count and slot count.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            for (int i = 0; i < aex_pkg::CFG_WORDS; i++) begin
                cfg_q[i] <= 32'h0000_0000;
            end
        end else if (WR_IN && (ADDR_IN < aex_pkg::ADDR_CUR_SLOT)) begin
            cfg_q[cfg_idx] <= WDATA_IN;
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            RDATA_OUT <= 32'h0000_0000;
        end else if (RD_IN) begin
            case (ADDR_IN)
                aex_pkg::ADDR_CUR_SLOT: RDATA_OUT <= cur_slot_q;
                aex_pkg::ADDR_USP_LO:   RDATA_OUT <= usp_q[31:0];
                aex_pkg::ADDR_USP_HI:   RDATA_OUT <= usp_q[63:32];
                aex_pkg::ADDR_UFP_LO:   RDATA_OUT <= ufp_q[31:0];
                aex_pkg::ADDR_UFP_HI:   RDATA_OUT <= ufp_q[63:32];
                aex_pkg::ADDR_STATUS:   RDATA_OUT <= {29'h0000_0000, enter_fail_q, state_q};
                default: begin
                    if (ADDR_IN < aex_pkg::ADDR_CUR_SLOT && ADDR_IN[1:0] == 2'h0) begin
                        RDATA_OUT <= cfg_q[cfg_idx];
                    end else begin
                        RDATA_OUT <= 32'h0000_0000;
                    end
                end
            endcase
        end else begin
            RDATA_OUT <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Slot index
    // ------------------------------------------------------------------
    // Hardware updates win over a software write in the same cycle, so an
    // exit or resume is never lost to a racing store.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            cur_slot_q <= 32'h0000_0000;
        end else if (state_q == aex_pkg::AEX_SYNTH) begin
            cur_slot_q <= cur_slot_q + aex_pkg::SLOT_STEP;
        end else if (resume_go && cur_slot_q != 32'h0000_0000) begin
            cur_slot_q <= cur_slot_q - aex_pkg::SLOT_STEP;
        end else if (WR_IN && ADDR_IN == aex_pkg::ADDR_CUR_SLOT) begin
            cur_slot_q <= WDATA_IN;
        end
    end

    // Entry and resume answers, one cycle after the request.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            ENTER_OK_OUT    <= 1'b0;
            ENTER_FAIL_OUT  <= 1'b0;
            RESUME_OK_OUT   <= 1'b0;
            RESUME_FAIL_OUT <= 1'b0;
            RESTORE_STB_OUT <= 1'b0;
            enter_fail_q    <= 1'b0;
        end else begin
            ENTER_OK_OUT    <= enter_go && (cur_slot_q < cfg_q[9]);
            ENTER_FAIL_OUT  <= enter_go && !(cur_slot_q < cfg_q[9]);
            RESUME_OK_OUT   <= resume_go && cur_slot_q != 32'h0000_0000;
            RESUME_FAIL_OUT <= resume_go && cur_slot_q == 32'h0000_0000;
            RESTORE_STB_OUT <= resume_go && cur_slot_q != 32'h0000_0000;
            if (enter_go) begin
                enter_fail_q <= !(cur_slot_q < cfg_q[9]);
            end
        end
    end

    // Untrusted stack copies and segments captured on a good entry; a
    // resume refreshes only the segments, as the stack copies still hold.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            usp_q <= 64'h0000_0000_0000_0000;
            ufp_q <= 64'h0000_0000_0000_0000;
            fs_q  <= 16'h0000;
            gs_q  <= 16'h0000;
        end else begin
            if (enter_go && cur_slot_q < cfg_q[9]) begin
                usp_q <= SP_IN;
                ufp_q <= FP_IN;
            end
            if ((enter_go && cur_slot_q < cfg_q[9]) ||
                (resume_go && cur_slot_q != 32'h0000_0000)) begin
                fs_q <= FS_SEL_IN;
                gs_q <= GS_SEL_IN;
            end
        end
    end

    // ------------------------------------------------------------------
    // Exit sequencer
    // ------------------------------------------------------------------
    // Idle, save into the current frame, then load synthetic state.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            state_q <= aex_pkg::AEX_IDLE;
        end else begin
            case (state_q)
                aex_pkg::AEX_IDLE: begin
                    if (EVT_IN) begin
                        state_q <= aex_pkg::AEX_SAVE;
                    end
                end
                aex_pkg::AEX_SAVE:  state_q <= aex_pkg::AEX_SYNTH;
                aex_pkg::AEX_SYNTH: state_q <= aex_pkg::AEX_IDLE;
                default:            state_q <= aex_pkg::AEX_IDLE;
            endcase
        end
    end

    // Event attributes held for the synthetic step.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            flags_q    <= 64'h0000_0000_0000_0000;
            cr2_q      <= 64'h0000_0000_0000_0000;
            fp_err_q   <= 1'b0;
            simd_q     <= 1'b0;
            pf_clear_q <= 1'b0;
            wide_q     <= 1'b0;
            stack_q    <= aex_pkg::STACK_APP;
        end else if (state_q == aex_pkg::AEX_IDLE && EVT_IN) begin
            flags_q  <= FLAGS_IN;
            cr2_q    <= CR2_IN;
            fp_err_q <= EVT_FP_ERR_IN;
            simd_q   <= EVT_SIMD_IN;
            // A fault taken while delivering the event is not the event.
            pf_clear_q <= EVT_PF_IN && !EVT_PF_VMEXIT_IN
                          && !EVT_PF_DELIVERY_IN;
            wide_q   <= MODE64_IN;
            if (IST_USE_IN) begin
                stack_q <= aex_pkg::STACK_IST;
            end else if (PRIV_CHANGE_IN) begin
                stack_q <= aex_pkg::STACK_RING;
            end else begin
                stack_q <= aex_pkg::STACK_APP;
            end
        end
    end

    // Save strobe and frame address; the extended area starts the frame in
    // the standard save-instruction layout, so the same address serves it.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            SAVE_STB_OUT   <= 1'b0;
            FRAME_ADDR_OUT <= 64'h0000_0000_0000_0000;
        end else begin
            SAVE_STB_OUT <= (state_q == aex_pkg::AEX_IDLE) && EVT_IN;
            if (((state_q == aex_pkg::AEX_IDLE) && EVT_IN) ||
                (resume_go && cur_slot_q != 32'h0000_0000)) begin
                FRAME_ADDR_OUT <= frame_addr;
            end
        end
    end

    // ------------------------------------------------------------------
    // Synthetic state
    // ------------------------------------------------------------------
    // Values land in one cycle; the wide flag tells the register file
    // whether to write all 64 bits or only the low half.
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            SYNTH_STB_OUT  <= 1'b0;
            SYNTH_WIDE_OUT <= 1'b0;
            ZERO_DSI_OUT   <= 1'b0;
            EXT_ZERO_OUT   <= 1'b0;
            X87_INIT_OUT   <= 1'b0;
            INIT_FEAT_OUT  <= aex_pkg::INIT_FEAT_MASK;
            INIT_HDR_OUT   <= aex_pkg::INIT_HDR_BITS;
            ACC_OUT        <= 64'h0000_0000_0000_0000;
            BASE_GPR_OUT   <= 64'h0000_0000_0000_0000;
            CNT_OUT        <= 64'h0000_0000_0000_0000;
            SP_OUT         <= 64'h0000_0000_0000_0000;
            FP_OUT         <= 64'h0000_0000_0000_0000;
            IP_OUT         <= 64'h0000_0000_0000_0000;
            FLAGS_OUT      <= 64'h0000_0000_0000_0000;
            FCW_OUT        <= aex_pkg::FCW_OTHER;
            FSW_OUT        <= aex_pkg::FSW_OTHER;
            SIMD_CS_OUT    <= aex_pkg::SIMD_CS_OTHER;
            CR2_OUT        <= 64'h0000_0000_0000_0000;
            CR2_WE_OUT     <= 1'b0;
            FS_SEL_OUT     <= 16'h0000;
            GS_SEL_OUT     <= 16'h0000;
            STACK_SEL_OUT  <= aex_pkg::STACK_APP;
        end else begin
            SYNTH_STB_OUT <= 1'b0;
            ZERO_DSI_OUT  <= 1'b0;
            EXT_ZERO_OUT  <= 1'b0;
            X87_INIT_OUT  <= 1'b0;
            CR2_WE_OUT    <= 1'b0;
            if (state_q == aex_pkg::AEX_SAVE) begin
                SYNTH_STB_OUT  <= 1'b1;
                SYNTH_WIDE_OUT <= wide_q;
                ZERO_DSI_OUT   <= 1'b1;
                EXT_ZERO_OUT   <= wide_q;
                X87_INIT_OUT   <= 1'b1;
                INIT_FEAT_OUT  <= aex_pkg::INIT_FEAT_MASK;
                INIT_HDR_OUT   <= aex_pkg::INIT_HDR_BITS;
                ACC_OUT        <= aex_pkg::RESUME_LEAF_IDX;
                BASE_GPR_OUT   <= tcs_ptr;
                CNT_OUT        <= exit_ptr;
                IP_OUT         <= exit_ptr;
                SP_OUT         <= usp_q;
                FP_OUT         <= ufp_q;
                FLAGS_OUT      <= flags_q & ~aex_pkg::FLAGS_CLR_MASK;
                FCW_OUT <= fp_err_q ? aex_pkg::FCW_FP_ERR : aex_pkg::FCW_OTHER;
                FSW_OUT <= fp_err_q ? aex_pkg::FSW_FP_ERR : aex_pkg::FSW_OTHER;
                SIMD_CS_OUT <= simd_q ? aex_pkg::SIMD_CS_FAULT
                                      : aex_pkg::SIMD_CS_OTHER;
                CR2_OUT        <= cr2_q & aex_pkg::CR2_LOW_CLR;
                CR2_WE_OUT     <= pf_clear_q;
                FS_SEL_OUT     <= fs_q;
                GS_SEL_OUT     <= gs_q;
                STACK_SEL_OUT  <= stack_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);

    sequence exit_start_s;
        state_q == aex_pkg::AEX_IDLE && EVT_IN;
    endsequence

    sequence exit_steps_s;
        SAVE_STB_OUT ##1 SYNTH_STB_OUT;
    endsequence

    exit_sequence_a: assert property (exit_start_s |=> exit_steps_s)
        else $error("Exit did not save then load synthetic state.");

    slot_increment_a: assert property (exit_start_s ##1 1'b1 ##1 1'b1
        |=> cur_slot_q == $past(cur_slot_q) + aex_pkg::SLOT_STEP)
        else $error("Current slot did not step up after exit.");

    exit_pointer_a: assert property (SYNTH_STB_OUT |->
        IP_OUT == exit_ptr && CNT_OUT == exit_ptr)
        else $error("Instruction pointer not loaded with exit pointer.");

    stack_restore_a: assert property (SYNTH_STB_OUT |->
        SP_OUT == usp_q && FP_OUT == ufp_q)
        else $error("Stack pointers not restored from untrusted copies.");

    leaf_index_a: assert property (SYNTH_STB_OUT |->
        ACC_OUT == aex_pkg::RESUME_LEAF_IDX && BASE_GPR_OUT == tcs_ptr)
        else $error("Accumulator or base register synthetic value wrong.");

    flags_mask_a: assert property (exit_start_s |-> ##2
        FLAGS_OUT == ($past(FLAGS_IN, 2) & ~aex_pkg::FLAGS_CLR_MASK))
        else $error("Flags not masked as required on exit.");

    ext_zero_a: assert property (exit_start_s |-> ##2
        EXT_ZERO_OUT == $past(MODE64_IN, 2) && SYNTH_WIDE_OUT == $past(MODE64_IN, 2))
        else $error("Extended zeroing or width does not follow the mode.");

    fpu_words_a: assert property (exit_start_s |-> ##2
        FCW_OUT == ($past(EVT_FP_ERR_IN, 2) ? aex_pkg::FCW_FP_ERR : aex_pkg::FCW_OTHER)
        && FSW_OUT == ($past(EVT_FP_ERR_IN, 2) ? aex_pkg::FSW_FP_ERR : aex_pkg::FSW_OTHER))
        else $error("Floating-point control or status word wrong.");

    simd_word_a: assert property (exit_start_s |-> ##2 SIMD_CS_OUT ==
        ($past(EVT_SIMD_IN, 2) ? aex_pkg::SIMD_CS_FAULT : aex_pkg::SIMD_CS_OTHER))
        else $error("SIMD control word wrong.");

    fault_addr_a: assert property (exit_start_s |-> ##2 CR2_WE_OUT ==
        ($past(EVT_PF_IN, 2) && !$past(EVT_PF_VMEXIT_IN, 2)
         && !$past(EVT_PF_DELIVERY_IN, 2)))
        else $error("Fault-address write enable wrong.");

    no_stray_cr2_a: assert property (CR2_WE_OUT |->
        CR2_OUT[11:0] == 12'h000 && SYNTH_STB_OUT)
        else $error("Fault-address written outside a clearing exit.");

    enter_gate_a: assert property (enter_go |=>
        ENTER_OK_OUT == ($past(cur_slot_q) < $past(cfg_q[9])) && ENTER_OK_OUT != ENTER_FAIL_OUT)
        else $error("Entry answer disagrees with slot check.");

    resume_free_a: assert property (resume_go && cur_slot_q != 32'h0000_0000 |=>
        RESUME_OK_OUT && cur_slot_q == $past(cur_slot_q) - aex_pkg::SLOT_STEP)
        else $error("Resume did not release the current frame.");

endmodule : aex_unit

// File: dv/tb_top.sv
// Self-checking bench for the asynchronous enclave exit unit.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------------
    // Stimulus, outputs and bench model state
    // ------------------------------------------------------------------
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, evt = 1'b0, ent = 1'b0, res = 1'b0;
    logic        fpe = 1'b0, sme = 1'b0, pf = 1'b0, pfv = 1'b0, pfd = 1'b0, m64 = 1'b0;
    logic        prv = 1'b0, interrupt_stack_table = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] fsi = 16'h0000, gsi = 16'h0000, fs, gs, fso, gso, fpu_control_word, fpu_status_word;
    logic [31:0] wdata = 32'h0, seed = 32'h0001_7261, pages = 32'h3, rdata, simo;
    logic [63:0] flg = 64'h0, cr2 = 64'h0, spi = 64'h0, fpi = 64'h0, ep, tp, base, off, usp, ufp;
    logic [63:0] fa, acc, bg, cnt, spo, fpo, ipo, flo, cr2o;
    logic        oke, fle, okr, flr, sv, rs, syn, wide, zd, ez, xi, cwe;
    logic [1:0]  ift, ihd, ss;
    integer      slot = 0, mismatches = 0, n_checks = 0;

    aex_unit i_dut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .EVT_IN(evt), .EVT_FP_ERR_IN(fpe),
        .EVT_SIMD_IN(sme), .EVT_PF_IN(pf), .EVT_PF_VMEXIT_IN(pfv), .EVT_PF_DELIVERY_IN(pfd),
        .MODE64_IN(m64), .PRIV_CHANGE_IN(prv), .IST_USE_IN(interrupt_stack_table), .FLAGS_IN(flg), .CR2_IN(cr2),
        .SP_IN(spi), .FP_IN(fpi), .FS_SEL_IN(fsi), .GS_SEL_IN(gsi), .ENTER_REQ_IN(ent),
        .RESUME_REQ_IN(res), .ENTER_OK_OUT(oke), .ENTER_FAIL_OUT(fle), .RESUME_OK_OUT(okr),
        .RESUME_FAIL_OUT(flr), .SAVE_STB_OUT(sv), .RESTORE_STB_OUT(rs), .FRAME_ADDR_OUT(fa),
        .SYNTH_STB_OUT(syn), .SYNTH_WIDE_OUT(wide), .ZERO_DSI_OUT(zd), .EXT_ZERO_OUT(ez),
        .X87_INIT_OUT(xi), .INIT_FEAT_OUT(ift), .INIT_HDR_OUT(ihd), .ACC_OUT(acc),
        .BASE_GPR_OUT(bg), .CNT_OUT(cnt), .SP_OUT(spo), .FP_OUT(fpo), .IP_OUT(ipo),
        .FLAGS_OUT(flo), .FCW_OUT(fpu_control_word), .FSW_OUT(fpu_status_word), .SIMD_CS_OUT(simo), .CR2_OUT(cr2o),
        .CR2_WE_OUT(cwe), .FS_SEL_OUT(fso), .GS_SEL_OUT(gso), .STACK_SEL_OUT(ss));

    // Free-running core clock, 10 ns period.
    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : rnd

    // Frame address follows base, offset and whole pages per slot.
    function automatic logic [63:0] faddr(input integer s);
        return base + off + 64'(s) * 64'(pages) * 64'h0000_0000_0000_1000;
    endfunction : faddr

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr32

    task automatic wr64(input logic [7:0] a, input logic [63:0] d);
        wr32(a, d[31:0]);
        wr32(a + 8'h04, d[63:32]);
    endtask : wr64

    // Read data stand only in the cycle after the strobe, so it is sampled there.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", 64'(rdata), 64'(e));
    endtask : rd_chk

    // Entry or resume with fresh pointer and segment values; the model follows on success.
    task automatic request(input logic e, input logic ok);
        logic [31:0] r;
        r = rnd();
        @(posedge clk);
        ent <= e;
        res <= !e;
        fsi <= r[15:0];
        gsi <= r[31:16];
        spi <= {rnd(), r};
        fpi <= {r, rnd()};
        @(posedge clk);
        ent <= 1'b0;
        res <= 1'b0;
        #1;
        if (e) begin
            chk("enter_ok", 64'(oke), 64'(ok));
            chk("enter_fail", 64'(fle), 64'(!ok));
            if (ok) begin
                usp = spi;
                ufp = fpi;
            end
        end else begin
            chk("resume_ok", 64'(okr), 64'(ok));
            chk("resume_fail", 64'(flr), 64'(!ok));
            chk("restore", 64'(rs), 64'(ok));
            if (ok) begin
                chk("restore_frame", fa, faddr(slot - 1));
                slot--;
            end
        end
        if (ok) begin
            fs = fsi;
            gs = gsi;
        end
    endtask : request

    // One exit with random attributes, checked at the save and the synthetic cycle.
    task automatic aex();
        logic [31:0] r;
        logic [63:0] m;
        r = rnd();
        @(posedge clk);
        evt <= 1'b1;
        {fpe, sme, pf, pfv, pfd, m64, prv, interrupt_stack_table} <= r[7:0];
        flg <= {rnd(), r};
        cr2 <= {r, rnd()};
        @(posedge clk);
        evt <= 1'b0;
        #1 chk("save", 64'(sv), 64'h1);
        chk("frame", fa, faddr(slot));
        @(posedge clk);
        #1 m = m64 ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
        chk("synth", {zd, xi, syn, wide, ez, ift, ihd}, {3'h7, m64, m64, 4'hC});
        chk("acc", acc & m, 64'h3 & m);
        chk("basegpr", bg & m, tp & m);
        chk("cnt", cnt & m, ep & m);
        chk("ip", ipo & m, ep & m);
        chk("sp", spo & m, usp & m);
        chk("fp", fpo & m, ufp & m);
        chk("flags", flo & m, flg & ~aex_pkg::FLAGS_CLR_MASK & m);
        chk("fcw", 64'(fpu_control_word), fpe ? 64'h037E : 64'h037F);
        chk("fsw", 64'(fpu_status_word), fpe ? 64'h8081 : 64'h0000);
        chk("simd", 64'(simo), sme ? 64'h1F01 : 64'h1FB0);
        chk("cr2we", 64'(cwe), 64'(pf & !pfv & !pfd));
        chk("cr2", cr2o, cr2 & 64'hFFFF_FFFF_FFFF_F000);
        chk("fs_gs", {fso, gso}, {fs, gs});
        chk("stack", 64'(ss), interrupt_stack_table ? 64'h2 : (prv ? 64'h1 : 64'h0));
        slot++;
    endtask : aex

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Main sequence: configure, exit and resume, fill the slots, refuse.
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        ep = {rnd(), rnd()};
        tp = {rnd(), rnd()};
        base = {rnd(), 32'h0};
        off = {32'h0, rnd()};
        wr64(aex_pkg::ADDR_EXIT_PTR_LO, ep);
        wr64(aex_pkg::ADDR_TCS_PTR_LO, tp);
        wr64(aex_pkg::ADDR_BASE_LO, base);
        wr64(aex_pkg::ADDR_OFFSET_LO, off);
        wr32(aex_pkg::ADDR_FRAME_PAGES, pages);
        wr32(aex_pkg::ADDR_SLOT_COUNT, 32'h2);
        rd_chk(aex_pkg::ADDR_SLOT_COUNT, 32'h2);
        rd_chk(8'h40, 32'h0);
        request(1'b1, 1'b1);
        repeat (6) begin
            aex();
            request(1'b0, 1'b1);
        end
        aex();
        aex();
        rd_chk(aex_pkg::ADDR_CUR_SLOT, 32'h2);
        request(1'b1, 1'b0);
        request(1'b0, 1'b1);
        request(1'b0, 1'b1);
        request(1'b0, 1'b0);
        request(1'b1, 1'b1);
        report_and_stop();
    end

    // Watchdog against a hang.
    initial begin
        #500000;
        mismatches++;
        report_and_stop();
    end
endmodule : tb_top
